// ---- logic/mis_regs.svh ----
// Register offsets, field positions and reset values of the instruction unit.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef MIS_REGS_SVH
`define MIS_REGS_SVH
`define MIS_OFF_INSTR 8'h00
`define MIS_OFF_WORK 8'h04
`define MIS_OFF_STATUS 8'h08
`define MIS_OFF_PC 8'h0c
`define MIS_OFF_MADDR 8'h10
`define MIS_OFF_MDATA 8'h14
`define MIS_OFF_WAKE 8'h18
`define MIS_OPC_LSB 16
`define MIS_OPC_MSB 19
`define MIS_ZERO_BIT 0
`define MIS_PD_FLAG_BIT 1
`define MIS_TO_BIT 2
`define MIS_HALT_BIT 3
`define MIS_BUSY_BIT 4
`define MIS_RST_WORK 8'h00
`define MIS_RST_PC 12'h000
`endif

// ---- logic/mis_pkg.sv ----
// Types shared by the instruction unit.
// Assumes mis_regs.svh supplies the numeric constants.
package mis_pkg;
  typedef enum logic [3:0] {
    MIS_OP_NOP = 4'h0,
    MIS_OP_DEC_TO_WORK = 4'h1,
    MIS_OP_POWER_DOWN = 4'h2,
    MIS_OP_INC_IN_PLACE = 4'h3,
    MIS_OP_ADD_ONE_INTO_WORK = 4'h4,
    MIS_OP_UNCOND_BRANCH = 4'h5,
    MIS_OP_LOAD_WORK_FROM_MEM = 4'h6,
    MIS_OP_LOAD_WORK_IMM = 4'h7
  } mis_op_t;
  typedef enum logic {
    MIS_ST_RUN = 1'b0,
    MIS_ST_DUMMY = 1'b1
  } mis_state_t;
endpackage : mis_pkg

// ---- logic/mis_core.sv ----
// Executes a subset of 8-bit core instructions issued over APB.
// Assumes a single pclk domain; the watchdog sits outside and obeys the clear pulse.
//
// How it works
// RQ1: Decrement-to-working writes memory byte minus one to working register, only zero flag.
// RQ2: Power-down halts execution and stops the system clock.
// RQ3: Memory and registers keep their contents on power-down entry.
// RQ4: Power-down clears the watchdog counter and its prescaler.
// RQ5: Power-down sets power-down flag, clears watchdog expiry flag, nothing else.
// RQ6: Increment-in-place writes memory byte plus one back, only zero flag.
// RQ7: Add-one-into-working puts memory byte plus one in working register.
// RQ8: Add-one-into-working leaves the source memory byte unchanged.
// RQ9: Branch loads the program counter with the encoded address, no flag change.
// RQ10: Branch takes two cycles with a dummy cycle inserted.
// RQ11: Load-from-memory copies memory byte to working register, no flag change.
// RQ12: Load-immediate puts the encoded constant in working register, no flag change.
// RQ13: Zero flag set when 8-bit result is zero; arithmetic wraps modulo 256.
// RQ14: Every instruction except the branch completes in one cycle.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`include "mis_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module mis_core #(
  parameter int MEM_DEPTH = 16,
  parameter int AW = 4,
  parameter int PC_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Watchdog side effects
  input wire logic watchdog_expired,
  output logic watchdog_clear,
  output logic clk_stop
);
  import mis_pkg::*;

  logic [7:0] mem_reg [MEM_DEPTH];
  logic [7:0] work_reg;
  logic [PC_W-1:0] pc_reg;
  logic zero_reg;
  logic pd_flag_reg;
  logic to_reg;
  logic halt_reg;
  logic [AW-1:0] maddr_reg;
  mis_state_t state_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic pready_reg;
  logic watchdog_clear_reg;

  // APB decode
  wire logic setup_ph = psel & ~penable;
  wire logic access_wr = psel & penable & pwrite;
  wire logic wr_instr = access_wr & (paddr == `MIS_OFF_INSTR);
  wire logic wr_maddr = access_wr & (paddr == `MIS_OFF_MADDR);
  wire logic wr_mdata = access_wr & (paddr == `MIS_OFF_MDATA);
  wire logic wr_wake = access_wr & (paddr == `MIS_OFF_WAKE);
  wire logic mapped = (paddr == `MIS_OFF_INSTR) | (paddr == `MIS_OFF_WORK) | (paddr == `MIS_OFF_STATUS) |
                      (paddr == `MIS_OFF_PC) | (paddr == `MIS_OFF_MADDR) | (paddr == `MIS_OFF_MDATA) |
                      (paddr == `MIS_OFF_WAKE);

  // Instruction fields and issue
  wire mis_op_t op = mis_op_t'(pwdata[`MIS_OPC_MSB:`MIS_OPC_LSB]);
  wire logic [AW-1:0] op_addr = pwdata[AW-1:0];
  wire logic [7:0] op_imm = pwdata[7:0];
  wire logic [PC_W-1:0] op_target = pwdata[PC_W-1:0];
  wire logic busy = (state_reg == MIS_ST_DUMMY);
  wire logic issue = wr_instr & ~busy & ~halt_reg;
  wire logic [7:0] src = mem_reg[op_addr];
  // RQ13 modulo 256 wrap
  wire logic [7:0] plus_one = 8'(src + 8'h01);
  wire logic [7:0] minus_one = 8'(src - 8'h01);
  wire logic do_dec = issue & (op == MIS_OP_DEC_TO_WORK);
  wire logic do_pd = issue & (op == MIS_OP_POWER_DOWN);
  wire logic do_inc = issue & (op == MIS_OP_INC_IN_PLACE);
  wire logic do_add_work = issue & (op == MIS_OP_ADD_ONE_INTO_WORK);
  wire logic do_branch = issue & (op == MIS_OP_UNCOND_BRANCH);
  wire logic do_ldm = issue & (op == MIS_OP_LOAD_WORK_FROM_MEM);
  wire logic do_ldi = issue & (op == MIS_OP_LOAD_WORK_IMM);

  // Working register next value
  // RQ1 RQ7 RQ11 RQ12 destinations
  wire logic [7:0] work_next = do_dec ? minus_one :
                               do_add_work ? plus_one :
                               do_ldm ? src :
                               do_ldi ? op_imm : work_reg;
  wire logic work_load = do_dec | do_add_work | do_ldm | do_ldi;
  // RQ13 zero flag update
  wire logic zero_upd = do_dec | do_inc | do_add_work;
  wire logic [7:0] zres = do_dec ? minus_one : plus_one;
  wire logic zero_next = zero_upd ? (zres == 8'h00) : zero_reg;
  // RQ9 branch target, step on any other issue, otherwise hold
  wire logic [PC_W-1:0] pc_next = do_branch ? op_target : (issue ? PC_W'(pc_reg + 1'b1) : pc_reg);

  // Read mux
  wire logic [31:0] status_word = {27'h0000000, busy, halt_reg, to_reg, pd_flag_reg, zero_reg};
  wire logic [31:0] rd_word = (paddr == `MIS_OFF_WORK) ? {24'h000000, work_reg} :
                              (paddr == `MIS_OFF_STATUS) ? status_word :
                              (paddr == `MIS_OFF_PC) ? {{(32-PC_W){1'b0}}, pc_reg} :
                              (paddr == `MIS_OFF_MADDR) ? {{(32-AW){1'b0}}, maddr_reg} :
                              (paddr == `MIS_OFF_MDATA) ? {24'h000000, mem_reg[maddr_reg]} : 32'h00000000;

  // APB answer: zero wait, error on unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= 1'b1;
      if (setup_ph)
      begin
        prdata_reg <= pwrite ? 32'h00000000 : rd_word;
        pslverr_reg <= ~mapped;
      end
    end
  end

  // Data memory: software window and increment-in-place
  generate
    for (genvar i = 0; i < MEM_DEPTH; i++)
    begin : g_mem
      wire logic hit_sw = wr_mdata & (maddr_reg == AW'(i));
      wire logic hit_inc = do_inc & (op_addr == AW'(i));
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          mem_reg[i] <= 8'h00;
        // RQ6 write back in place
        else if (hit_inc)
          mem_reg[i] <= plus_one;
        else if (hit_sw)
          mem_reg[i] <= pwdata[7:0];
      end
      // RQ3 memory kept on power-down
      pd_mem_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        do_pd |=> $stable(mem_reg[i]))
        else $error("memory changed on power-down");
    end
  endgenerate

  // Core state, working register and program counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work_reg <= `MIS_RST_WORK;
      pc_reg <= `MIS_RST_PC;
      zero_reg <= 1'b0;
      maddr_reg <= '0;
      state_reg <= MIS_ST_RUN;
    end
    else
    begin
      if (work_load)
        work_reg <= work_next;
      pc_reg <= pc_next;
      zero_reg <= zero_next;
      if (wr_maddr)
        maddr_reg <= pwdata[AW-1:0];
      // RQ10 dummy cycle after branch
      case (state_reg)
        MIS_ST_RUN: state_reg <= do_branch ? MIS_ST_DUMMY : MIS_ST_RUN;
        MIS_ST_DUMMY: state_reg <= MIS_ST_RUN;
        default: state_reg <= MIS_ST_RUN;
      endcase
    end
  end

  // Power-down flags and clock stop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pd_flag_reg <= 1'b0;
      to_reg <= 1'b0;
      halt_reg <= 1'b0;
      watchdog_clear_reg <= 1'b0;
    end
    else
    begin
      // RQ5 flag effects; expiry set wins
      if (do_pd)
        pd_flag_reg <= 1'b1;
      if (watchdog_expired)
        to_reg <= 1'b1;
      else if (do_pd)
        to_reg <= 1'b0;
      // RQ2 halt and stop clock
      if (do_pd)
        halt_reg <= 1'b1;
      else if (wr_wake)
        halt_reg <= 1'b0;
      // RQ4 watchdog clear pulse
      watchdog_clear_reg <= do_pd;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign watchdog_clear = watchdog_clear_reg;
  assign clk_stop = halt_reg;

  // Checks
  sequence s_pd_issue;
    do_pd;
  endsequence
  sequence s_pd_done;
    halt_reg && pd_flag_reg && watchdog_clear_reg;
  endsequence

  dec_result_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    do_dec |=> (work_reg == $past(minus_one)) && (zero_reg == ($past(minus_one) == 8'h00)))
    else $error("decrement result wrong");
  pd_enter_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    s_pd_issue |=> s_pd_done)
    else $error("power-down not entered");
  pd_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    do_pd |=> $stable(work_reg) && (pc_reg == PC_W'($past(pc_reg) + 1'b1)) && $stable(zero_reg))
    else $error("state changed on power-down");
  halted_ignore_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    halt_reg && wr_instr |=> $stable(work_reg) && $stable(pc_reg))
    else $error("instruction ran while halted");
  pd_flags_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    do_pd && !watchdog_expired |=> pd_flag_reg && !to_reg && $stable(zero_reg))
    else $error("power-down flags wrong");
  watchdog_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    watchdog_clear_reg |-> $past(do_pd))
    else $error("watchdog clear without power-down");
  inc_place_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    do_inc |=> (mem_reg[$past(op_addr)] == $past(plus_one)) && $stable(work_reg))
    else $error("increment in place wrong");
  add_src_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    do_add_work |=> (mem_reg[$past(op_addr)] == $past(src)) && (work_reg == $past(plus_one)))
    else $error("add-one source or result wrong");
  branch_pc_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    do_branch |=> (pc_reg == $past(op_target)) && $stable(zero_reg) && $stable(to_reg))
    else $error("branch target wrong");
  branch_two_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    do_branch |=> busy ##1 !busy)
    else $error("branch not two cycles");
  ld_flags_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    do_ldm || do_ldi |=> $stable(zero_reg) && (work_reg == $past(do_ldm ? src : op_imm)))
    else $error("load wrong");
  single_cyc_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
    issue && !do_branch |=> !busy)
    else $error("instruction took extra cycle");

  // Further result, flag and bus checks
  // RQ1 source kept on decrement
  dec_mem_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    do_dec |=> mem_reg[$past(op_addr)] == $past(src))
    else $error("decrement changed memory");
  // RQ13 zero flag on increment
  inc_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    do_inc |=> zero_reg == ($past(plus_one) == 8'h00))
    else $error("increment zero flag wrong");
  // RQ13 zero flag on add-one
  add_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    do_add_work |=> (zero_reg == ($past(plus_one) == 8'h00)) && $stable(to_reg))
    else $error("add-one zero flag wrong");
  // RQ12 immediate load value
  ldi_value_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
    do_ldi |=> (work_reg == $past(op_imm)) && $stable(zero_reg) && $stable(pd_flag_reg))
    else $error("immediate load wrong");
  // RQ11 memory load value
  ldm_value_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    do_ldm |=> (work_reg == $past(src)) && $stable(to_reg))
    else $error("memory load wrong");
  // RQ2 halt held until wake
  halt_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    halt_reg && !wr_wake |=> halt_reg)
    else $error("halt dropped without wake");
  // RQ9 branch leaves flags alone
  branch_flags_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    do_branch |=> $stable(pd_flag_reg) && $stable(work_reg))
    else $error("branch changed state");
  // RQ10 dummy cycle refuses issue
  busy_refuse_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    busy && wr_instr |=> $stable(pc_reg) && $stable(work_reg))
    else $error("instruction ran in dummy cycle");
  // RQ14 one-step program counter
  pc_step_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
    issue && !do_branch |=> pc_reg == PC_W'($past(pc_reg) + 1'b1))
    else $error("program counter step wrong");
  // Unmapped address answers with error
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !mapped |=> pslverr_reg)
    else $error("no error on unmapped address");
endmodule : mis_core
`default_nettype wire

// ---- bench/mis_core_test.sv ----
// Self-checking bench for the instruction unit, driven over APB.
// Assumes a zero-wait APB slave and the register map of mis_regs.svh.
`include "mis_regs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
module mis_core_test;
  import mis_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic watchdog_expired = 1'b0;
  logic watchdog_clear;
  logic clk_stop;
  logic err;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int n_clear = 0;
  mis_core u_mis_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdog_expired(watchdog_expired), .watchdog_clear(watchdog_clear), .clk_stop(clk_stop));
  // Clock, timeout and clear-pulse counter
  always #25 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (watchdog_clear === 1'b1) n_clear++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  // One APB transfer, held until pready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    `CHK(r & m, e)
  endtask : rdc
  task automatic ins(input mis_op_t op, input logic [11:0] f);
    wr(`MIS_OFF_INSTR, {12'h000, op, 4'h0, f});
  endtask : ins
  task automatic mem(input logic [3:0] a, input logic [7:0] e);
    wr(`MIS_OFF_MADDR, {28'h0, a});
    rdc(`MIS_OFF_MDATA, 32'hff, {24'h0, e});
  endtask : mem
  // Working register, status and pc in one go
  task automatic state(input logic [7:0] w, input logic [4:0] s, input logic [11:0] p);
    rdc(`MIS_OFF_WORK, 32'hff, {24'h0, w});
    rdc(`MIS_OFF_STATUS, 32'h1f, {27'h0, s});
    rdc(`MIS_OFF_PC, 32'hfff, {20'h0, p});
  endtask : state
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    state(8'h00, 5'h00, 12'h000);
    wr(`MIS_OFF_MADDR, 32'h3); wr(`MIS_OFF_MDATA, 32'h00);
    wr(`MIS_OFF_MADDR, 32'h5); wr(`MIS_OFF_MDATA, 32'hff);
    wr(`MIS_OFF_MADDR, 32'h7); wr(`MIS_OFF_MDATA, 32'h01);
    $display("test reset done");
    ins(MIS_OP_DEC_TO_WORK, 12'h007);
    state(8'h00, 5'h01, 12'h001);
    mem(4'h7, 8'h01);
    ins(MIS_OP_DEC_TO_WORK, 12'h003);
    state(8'hff, 5'h00, 12'h002);
    ins(MIS_OP_INC_IN_PLACE, 12'h005);
    mem(4'h5, 8'h00);
    state(8'hff, 5'h01, 12'h003);
    ins(MIS_OP_ADD_ONE_INTO_WORK, 12'h007);
    state(8'h02, 5'h00, 12'h004);
    mem(4'h7, 8'h01);
    $display("test arithmetic done");
    ins(MIS_OP_LOAD_WORK_FROM_MEM, 12'h005);
    state(8'h00, 5'h00, 12'h005);
    ins(MIS_OP_DEC_TO_WORK, 12'h007);
    ins(MIS_OP_LOAD_WORK_IMM, 12'h05a);
    state(8'h5a, 5'h01, 12'h007);
    $display("test loads done");
    ins(MIS_OP_UNCOND_BRANCH, 12'habc);
    state(8'h5a, 5'h01, 12'habc);
    ins(MIS_OP_LOAD_WORK_IMM, 12'h033);
    state(8'h33, 5'h01, 12'habd);
    $display("test branch done");
    @(posedge pclk);
    watchdog_expired <= 1'b1;
    @(posedge pclk);
    watchdog_expired <= 1'b0;
    rdc(`MIS_OFF_STATUS, 32'h1f, 32'h05);
    ins(MIS_OP_POWER_DOWN, 12'h000);
    state(8'h33, 5'h0b, 12'habe);
    `CHK(clk_stop, 1'b1)
    `CHK(n_clear, 1)
    mem(4'h7, 8'h01);
    ins(MIS_OP_LOAD_WORK_IMM, 12'h077);
    state(8'h33, 5'h0b, 12'habe);
    wr(`MIS_OFF_WAKE, 32'h1);
    state(8'h33, 5'h03, 12'habe);
    `CHK(clk_stop, 1'b0)
    $display("test power-down done");
    rdc(8'h1c, 32'hffffffff, 32'h0);
    `CHK(err, 1'b1)
    $display("test unmapped done");
    stop_test();
  end
endmodule : mis_core_test
`default_nettype wire
